// *** rtl/vprc_pkg.sv ***
// constants shared by the video port reset and interrupt control block
package vprc_pkg;
    localparam int          NUM_PINS    = 24;
    localparam int          DATA_PINS   = 20;
    localparam int          PIN_CLK_OUT = 23;
    localparam int          NUM_CH      = 3;
    localparam int          CH_CAP_B    = 1;
    localparam int          CH_DISP     = 2;
    localparam int          CH_SEL_W    = 2;
    localparam int          CFG_W       = 8;
    localparam int          NUM_EVT     = 6;
    localparam int          EVT_PER_CH  = 3;
    localparam int          NUM_IRQ     = 12;
    localparam int          EDGE_W      = 2;
    localparam logic [EDGE_W-1:0] REL_EDGES = 2'h2;
    localparam logic [CFG_W-1:0]  CFG_RST   = 8'h00;
    localparam logic        EN_RST      = 1'b0;
    localparam logic        HALT_RST    = 1'b1;
    localparam logic        BLK_RST     = 1'b1;
    localparam logic        ARMED_RST   = 1'b1;
endpackage

// *** rtl/vprc_release.sv ***
// reset release paced by edges of a sampled module clock
`timescale 1ns/1ps
`default_nettype none
module vprc_release
    import vprc_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RSTN,
    input  wire logic start,
    input  wire logic hold,
    input  wire logic clk_ok,
    input  wire logic mod_clk,
    output logic      busy,
    output logic      done
);
    typedef struct packed {
        logic              busy;
        logic              prev;
        logic [EDGE_W-1:0] cnt;
        logic              done;
    } vprc_rel_st_t;

    vprc_rel_st_t st_q;
    vprc_rel_st_t st_d;

    always_comb begin
        st_d      = st_q;
        st_d.prev = mod_clk;
        st_d.done = 1'b0;
        // done blocks a restart while the requester drops its request
        if (start && !st_q.busy && !st_q.done) begin
            st_d.busy = 1'b1;
            st_d.cnt  = '0;
        end
        // gated module clock: no edges counted while disabled
        if (st_q.busy && clk_ok && mod_clk && !st_q.prev && st_q.cnt != REL_EDGES) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
        if (st_q.busy && !hold && st_q.cnt == REL_EDGES) begin
            st_d.busy = 1'b0;
            st_d.done = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busy = st_q.busy;
    assign done = st_q.done;
endmodule
`default_nettype wire

// *** rtl/vprc_irq.sv ***
// sticky interrupt flags with masks and a single edge pulse
`timescale 1ns/1ps
`default_nettype none
module vprc_irq
    import vprc_pkg::*;
(
    input  wire logic               CLK,
    input  wire logic               RSTN,
    input  wire logic               sreset,
    input  wire logic [NUM_IRQ-1:0] set,
    input  wire logic               clr_wr,
    input  wire logic [NUM_IRQ-1:0] clr_data,
    input  wire logic               mask_wr,
    input  wire logic [NUM_IRQ-1:0] mask_data,
    input  wire logic               gie_data,
    output logic [NUM_IRQ-1:0]      flags,
    output logic [NUM_IRQ-1:0]      mask,
    output logic                    gie,
    output logic                    pulse
);
    typedef struct packed {
        logic [NUM_IRQ-1:0] flags;
        logic [NUM_IRQ-1:0] mask;
        logic               gie;
        logic               armed;
        logic               pulse;
    } vprc_irq_st_t;

    vprc_irq_st_t       st_q;
    vprc_irq_st_t       st_d;
    logic [NUM_IRQ-1:0] clr;
    logic               active;

    always_comb begin
        st_d   = st_q;
        clr    = clr_wr ? clr_data : '0;
        active = st_q.gie && |(st_q.flags & st_q.mask);
        // write one clears; a new set in the same cycle wins
        st_d.flags = (st_q.flags & ~clr) | set;
        // per source enables and global gate
        if (mask_wr) begin
            st_d.mask = mask_data;
            st_d.gie  = gie_data;
        end
        // pulse while armed and an enabled flag is set, one per arming
        // one low cycle between pulses, so a quick re-arm never stretches one
        st_d.pulse = st_q.armed && active && !st_q.pulse;
        if (st_d.pulse) begin
            st_d.armed = 1'b0;
        end
        // clearing any set flag re-arms the pulse
        if (|(clr & st_q.flags) || !active) begin
            st_d.armed = 1'b1;
        end
        if (sreset) begin
            st_d.flags = '0;
            st_d.mask  = '0;
            st_d.gie   = 1'b0;
            st_d.armed = ARMED_RST;
            st_d.pulse = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_q       <= '0;
            st_q.armed <= ARMED_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign flags = st_q.flags;
    assign mask  = st_q.mask;
    assign gie   = st_q.gie;
    // one cycle wide, the cycle after enabled flags go nonzero with gie set
    assign pulse = st_q.pulse;
endmodule
`default_nettype wire

// *** rtl/vprc_top.sv ***
// video port reset, enable/halt gating, pin and interrupt control
`timescale 1ns/1ps
`default_nettype none
module vprc_top
    import vprc_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   RSTN,
    input  wire logic                   BUS_RST,
    input  wire logic                   PCR_WR,
    input  wire logic                   PCR_EN_WD,
    input  wire logic                   PCTL_WR,
    input  wire logic                   PCTL_HALT_WD,
    input  wire logic                   PCTL_RST_WD,
    input  wire logic                   PCTL_DISP_WD,
    input  wire logic [NUM_CH-1:0]      CH_WR,
    input  wire logic                   CH_EN_WD,
    input  wire logic                   CH_RST_WD,
    input  wire logic                   CH_BLK_WD,
    input  wire logic [CFG_W-1:0]       CH_CFG_WD,
    input  wire logic                   IRQ_MASK_WR,
    input  wire logic [NUM_IRQ-1:0]     IRQ_MASK_WD,
    input  wire logic                   IRQ_GIE_WD,
    input  wire logic                   IRQ_CLR_WR,
    input  wire logic [NUM_IRQ-1:0]     IRQ_CLR_WD,
    input  wire logic [NUM_IRQ-1:0]     IRQ_SRC,
    input  wire logic                   MMR_REQ,
    input  wire logic                   MMR_GPIO,
    input  wire logic                   DMA_REQ,
    input  wire logic                   DMA_RNW,
    input  wire logic [CH_SEL_W-1:0]    DMA_CH,
    input  wire logic                   VCLK_IN_A,
    input  wire logic                   VCLK_IN_B,
    input  wire logic [NUM_PINS-1:0]    PIN_FUNC_GPIO,
    input  wire logic [NUM_PINS-1:0]    GPIO_OUT,
    input  wire logic [NUM_PINS-1:0]    GPIO_OE,
    input  wire logic [NUM_PINS-1:0]    CORE_OUT,
    input  wire logic [NUM_PINS-1:0]    CORE_OE,
    input  wire logic [NUM_EVT-1:0]     DMA_EVT_REQ,
    output logic [NUM_PINS-1:0]         PIN_OUT,
    output logic [NUM_PINS-1:0]         PIN_OE,
    output logic                        MOD_CLK_EN,
    output logic                        PERIPH_EN,
    output logic                        PORT_HALT,
    output logic                        PORT_RST,
    output logic                        DISP_MODE,
    output logic [NUM_CH-1:0]           CH_EN,
    output logic [NUM_CH-1:0]           CH_RST,
    output logic [NUM_CH-1:0]           CH_BLK,
    output logic [NUM_CH*CFG_W-1:0]     CH_CFG,
    output logic [NUM_CH-1:0]           FIFO_FLUSH,
    output logic [NUM_CH-1:0]           REGS_DEFAULT,
    output logic [NUM_CH-1:0]           CNT_RUN,
    output logic [NUM_CH-1:0]           FIFO_LIVE,
    output logic                        DISP_DRIVE,
    output logic                        MMR_READY,
    output logic                        MMR_GRANT,
    output logic                        DMA_READY,
    output logic                        DMA_REAL,
    output logic [NUM_EVT-1:0]          DMA_EVT,
    output logic                        IRQ_PULSE,
    output logic [NUM_IRQ-1:0]          IRQ_FLAGS,
    output logic [NUM_IRQ-1:0]          IRQ_MASK,
    output logic                        IRQ_GIE
);
    typedef struct packed {
        logic                           periph_en;
        logic                           halt;
        logic                           soft_rst;
        logic                           disp_mode;
        logic [NUM_CH-1:0]              en;
        logic [NUM_CH-1:0]              rst;
        logic [NUM_CH-1:0]              blk;
        logic [NUM_CH-1:0][CFG_W-1:0]   cfg;
        logic [NUM_PINS-1:0]            pin_out;
        logic [NUM_PINS-1:0]            pin_oe;
        logic                           mod_clk_en;
        logic                           mmr_ready;
        logic                           mmr_grant;
        logic                           dma_ready;
        logic                           dma_real;
        logic                           disp_drive;
        logic [NUM_CH-1:0]              flush;
        logic [NUM_CH-1:0]              regs_def;
        logic [NUM_CH-1:0]              cnt_run;
        logic [NUM_CH-1:0]              fifo_live;
        logic [NUM_EVT-1:0]             evt;
    } vprc_top_st_t;

    vprc_top_st_t      st_q;
    vprc_top_st_t      st_d;
    logic              port_busy;
    logic              port_done;
    logic [NUM_CH-1:0] ch_busy;
    logic [NUM_CH-1:0] ch_done;
    logic [NUM_CH-1:0] ch_clk;
    logic              port_act;
    logic              port_live;
    logic              irq_reset;
    logic              reg_ok;

    // channel moves data only when enabled, unblocked and out of reset
    function automatic logic ch_live(input logic en, input logic blk, input logic busy);
        ch_live = en && !blk && !busy;
    endfunction

    // channel counters and output drive need only enable and no reset
    function automatic logic ch_run(input logic en, input logic busy);
        ch_run = en && !busy;
    endfunction

    assign ch_clk    = {VCLK_IN_A, VCLK_IN_B, VCLK_IN_A};
    // bus reset and software reset share one reset path
    assign port_act  = BUS_RST || st_q.soft_rst || port_busy;
    assign port_live = st_q.periph_en && !st_q.halt && !port_act;
    assign irq_reset = port_act;
    // only pin function registers and the enable register answer while disabled
    assign reg_ok    = st_q.periph_en && !port_act;

    // port logic leaves reset on input video clock edges
    vprc_release u_port_rel (
        .CLK     (CLK),
        .RSTN    (RSTN),
        .start   (BUS_RST || st_q.soft_rst),
        .hold    (BUS_RST),
        .clk_ok  (st_q.periph_en),
        .mod_clk (VCLK_IN_A),
        .busy    (port_busy),
        .done    (port_done)
    );

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch_rel
        // channel reset needs its channel clock toggling
        vprc_release u_ch_rel (
            .CLK     (CLK),
            .RSTN    (RSTN),
            .start   (st_q.rst[c]),
            .hold    (1'b0),
            .clk_ok  (st_q.periph_en),
            .mod_clk (ch_clk[c]),
            .busy    (ch_busy[c]),
            .done    (ch_done[c])
        );
    end

    // twelve status sources feed one interrupt
    vprc_irq u_irq (
        .CLK       (CLK),
        .RSTN      (RSTN),
        .sreset    (irq_reset),
        .set       (IRQ_SRC),
        .clr_wr    (IRQ_CLR_WR && reg_ok),
        .clr_data  (IRQ_CLR_WD),
        .mask_wr   (IRQ_MASK_WR && reg_ok),
        .mask_data (IRQ_MASK_WD),
        .gie_data  (IRQ_GIE_WD),
        .flags     (IRQ_FLAGS),
        .mask      (IRQ_MASK),
        .gie       (IRQ_GIE),
        .pulse     (IRQ_PULSE)
    );

    always_comb begin
        int unsigned chs;
        chs  = 0;
        st_d = st_q;

        if (PCR_WR) begin
            st_d.periph_en = PCR_EN_WD;
        end

        if (PCTL_WR && reg_ok) begin
            if (st_q.halt) begin
                st_d.halt      = PCTL_HALT_WD;
                st_d.disp_mode = PCTL_DISP_WD;
            end
            // after halt clears only the reset bit is taken
            if (PCTL_RST_WD) begin
                st_d.soft_rst = 1'b1;
            end
        end

        for (int c = 0; c < NUM_CH; c++) begin
            if (CH_WR[c] && reg_ok && !ch_busy[c]) begin
                if (CH_RST_WD) begin
                    st_d.rst[c] = 1'b1;
                end
                st_d.en[c]  = CH_EN_WD;
                st_d.blk[c] = CH_BLK_WD;
                // other channel bits locked once enabled
                if (!st_q.en[c]) begin
                    st_d.cfg[c] = CH_CFG_WD;
                end
            end
            // while in reset: defaults, enable cleared
            if (ch_busy[c]) begin
                st_d.en[c]  = EN_RST;
                st_d.blk[c] = BLK_RST;
                st_d.cfg[c] = CFG_RST;
            end
            if (ch_done[c] && !(CH_WR[c] && reg_ok && CH_RST_WD)) begin
                st_d.rst[c] = 1'b0;
            end
        end

        // self-clear once the release finishes, halt left set
        if (port_done && !(PCTL_WR && reg_ok && PCTL_RST_WD)) begin
            st_d.soft_rst = 1'b0;
        end

        // port reset defaults everything below the enable
        if (port_act) begin
            st_d.halt      = HALT_RST;
            st_d.disp_mode = 1'b0;
            st_d.en        = {NUM_CH{EN_RST}};
            st_d.rst       = '0;
            st_d.blk       = {NUM_CH{BLK_RST}};
            st_d.cfg       = {NUM_CH{CFG_RST}};
        end
        // bus reset alone clears the enable bit
        if (BUS_RST) begin
            st_d.periph_en = EN_RST;
            st_d.soft_rst  = 1'b0;
        end

        // module clocks run only while enabled
        st_d.mod_clk_en = st_d.periph_en;

        // every access is acknowledged the next cycle
        st_d.mmr_ready = MMR_REQ;
        st_d.dma_ready = DMA_REQ;
        // grant only for pin function registers while disabled
        st_d.mmr_grant = MMR_REQ && (MMR_GPIO || reg_ok);
        // false acknowledge unless the addressed mode is live
        st_d.dma_real = 1'b0;
        if (DMA_REQ && port_live && DMA_CH <= CH_SEL_W'(CH_DISP)) begin
            chs = int'(DMA_CH);
            if (chs == CH_DISP) begin
                st_d.dma_real = !DMA_RNW && ch_run(st_q.en[chs], ch_busy[chs]);
            end else begin
                st_d.dma_real = DMA_RNW && ch_run(st_q.en[chs], ch_busy[chs]);
            end
        end

        for (int c = 0; c < NUM_CH; c++) begin
            st_d.flush[c]     = port_act || ch_busy[c];
            st_d.regs_def[c]  = port_act || ch_busy[c];
            st_d.cnt_run[c]   = port_live && ch_run(st_q.en[c], ch_busy[c]);
            // data moves only after block clears
            st_d.fifo_live[c] = port_live && ch_live(st_q.en[c], st_q.blk[c], ch_busy[c]);
        end

        // display drives defaults and blanking once enabled
        st_d.disp_drive = port_live && ch_run(st_q.en[CH_DISP], ch_busy[CH_DISP]);

        // six events, three per capture channel, gated by owning channel, or by display in display mode
        for (int k = 0; k < NUM_EVT; k++) begin
            chs = st_q.disp_mode ? CH_DISP : k / EVT_PER_CH;
            // no events in reset or while blocked
            st_d.evt[k] = DMA_EVT_REQ[k] && port_live
                          && ch_live(st_q.en[chs], st_q.blk[chs], ch_busy[chs]);
        end

        for (int p = 0; p < NUM_PINS; p++) begin
            st_d.pin_out[p] = PIN_FUNC_GPIO[p] ? GPIO_OUT[p] : CORE_OUT[p];
            if (PIN_FUNC_GPIO[p]) begin
                // general use pins follow their own enables
                st_d.pin_oe[p] = GPIO_OE[p];
            end else if (p == PIN_CLK_OUT) begin
                // clock-out may drive once unhalted in display mode
                st_d.pin_oe[p] = CORE_OE[p] && port_live && st_q.disp_mode;
            end else begin
                // data and sync pins only through display drive
                st_d.pin_oe[p] = CORE_OE[p] && st_d.disp_drive;
            end
            if (BUS_RST) begin
                st_d.pin_oe[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        // power-on reset: all pin enables low at once
        if (!RSTN) begin
            st_q      <= '0;
            st_q.halt <= HALT_RST;
            st_q.blk  <= {NUM_CH{BLK_RST}};
        end else begin
            st_q <= st_d;
        end
    end

    assign PIN_OUT      = st_q.pin_out;
    assign PIN_OE       = st_q.pin_oe;
    assign MOD_CLK_EN   = st_q.mod_clk_en;
    assign PERIPH_EN    = st_q.periph_en;
    assign PORT_HALT    = st_q.halt;
    assign PORT_RST     = st_q.soft_rst;
    assign DISP_MODE    = st_q.disp_mode;
    assign CH_EN        = st_q.en;
    assign CH_RST       = st_q.rst;
    assign CH_BLK       = st_q.blk;
    assign CH_CFG       = st_q.cfg;
    assign FIFO_FLUSH   = st_q.flush;
    assign REGS_DEFAULT = st_q.regs_def;
    assign CNT_RUN      = st_q.cnt_run;
    assign FIFO_LIVE    = st_q.fifo_live;
    assign DISP_DRIVE   = st_q.disp_drive;
    assign MMR_READY    = st_q.mmr_ready;
    assign MMR_GRANT    = st_q.mmr_grant;
    assign DMA_READY    = st_q.dma_ready;
    assign DMA_REAL     = st_q.dma_real;
    assign DMA_EVT      = st_q.evt;
endmodule
`default_nettype wire

// *** tb/vprc_monitor.sv ***
// assertion checker for the port reset, gating and interrupt pulse
`timescale 1ns/1ps
`default_nettype none
module vprc_monitor
    import vprc_pkg::*;
(
    input wire logic                CLK,
    input wire logic                RSTN,
    input wire logic                BUS_RST,
    input wire logic                MMR_REQ,
    input wire logic                MMR_GPIO,
    input wire logic                DMA_REQ,
    input wire logic [NUM_PINS-1:0] PIN_FUNC_GPIO,
    input wire logic [NUM_PINS-1:0] PIN_OE,
    input wire logic                MOD_CLK_EN,
    input wire logic                PERIPH_EN,
    input wire logic                PORT_HALT,
    input wire logic                MMR_READY,
    input wire logic                MMR_GRANT,
    input wire logic                DMA_READY,
    input wire logic                IRQ_PULSE,
    input wire logic [NUM_IRQ-1:0]  IRQ_FLAGS,
    input wire logic [NUM_IRQ-1:0]  IRQ_MASK,
    input wire logic                IRQ_GIE
);
    logic any_en;
    assign any_en = |(IRQ_FLAGS & IRQ_MASK);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    AST_MMR_ACK: assert property (MMR_REQ |=> MMR_READY)
        else $error("register access not acknowledged");
    AST_DMA_ACK: assert property (DMA_REQ |=> DMA_READY)
        else $error("dma access not acknowledged");
    AST_GRANT_GATE: assert property (MMR_REQ && !MMR_GPIO && !PERIPH_EN |=> !MMR_GRANT)
        else $error("register granted while disabled");
    AST_BUS_RESET: assert property (BUS_RST |=> !PERIPH_EN && PORT_HALT && PIN_OE == '0)
        else $error("bus reset state wrong");
    AST_PIN_HIZ: assert property (!PERIPH_EN || PORT_HALT |=> (PIN_OE & ~$past(PIN_FUNC_GPIO)) == '0)
        else $error("port pin driven while idle");
    AST_CLK_GATE: assert property (!PERIPH_EN |-> !MOD_CLK_EN)
        else $error("module clock running while disabled");
    AST_IRQ_WIDTH: assert property (IRQ_PULSE |=> !IRQ_PULSE)
        else $error("interrupt pulse too long");
    AST_IRQ_CAUSE: assert property (IRQ_PULSE |-> $past(IRQ_GIE) && ($past(IRQ_FLAGS) & $past(IRQ_MASK)) != '0)
        else $error("interrupt without enabled flag");
    AST_IRQ_RAISE: assert property ($rose(any_en) && IRQ_GIE |=> IRQ_PULSE)
        else $error("interrupt pulse missing");
    cover property (IRQ_PULSE);
    cover property (MMR_REQ && !PERIPH_EN ##1 MMR_READY);
    cover property (BUS_RST ##1 !BUS_RST);
endmodule
bind vprc_top vprc_monitor vprc_monitor_inst (.*);
`default_nettype wire

// *** tb/vprc_dma_model.sv ***
// dma master model issuing single accesses toward the port
`timescale 1ns/1ps
`default_nettype none
module vprc_dma_model
    import vprc_pkg::*;
(
    input  wire logic                CLK,
    input  wire logic                go,
    input  wire logic                rnw,
    input  wire logic [CH_SEL_W-1:0] ch,
    input  wire logic                DMA_READY,
    input  wire logic                DMA_REAL,
    output logic                     DMA_REQ = 1'b0,
    output logic                     DMA_RNW = 1'b0,
    output logic [CH_SEL_W-1:0]      DMA_CH = '0,
    output logic                     real_ack = 1'b0,
    output int                       n_ack = 0
);
    always @(posedge CLK) begin
        DMA_REQ <= #1 go;
        if (go) begin
            DMA_RNW <= #1 rnw;
            DMA_CH  <= #1 ch;
        end else if (DMA_READY === 1'b1) begin
            // released lines flip so a stale value is never trusted
            DMA_RNW  <= #1 ~DMA_RNW;
            DMA_CH   <= #1 ~DMA_CH;
            real_ack <= DMA_REAL;
            n_ack    <= n_ack + 1;
        end
    end
endmodule
`default_nettype wire

// *** tb/vprc_top_test.sv ***
// self-checking bench for the port reset and interrupt block
`timescale 1ns/1ps
`default_nettype none
module vprc_top_test
    import vprc_pkg::*;
;
    logic CLK, RSTN, BUS_RST, PCR_WR, PCR_EN_WD, PCTL_WR, PCTL_HALT_WD, PCTL_RST_WD;
    logic PCTL_DISP_WD, CH_EN_WD, CH_RST_WD, CH_BLK_WD, IRQ_MASK_WR, IRQ_GIE_WD, IRQ_CLR_WR;
    logic MMR_REQ, MMR_GPIO, DMA_REQ, DMA_RNW, VCLK_IN_A = 1'b0, VCLK_IN_B, MOD_CLK_EN, PERIPH_EN;
    logic PORT_HALT, PORT_RST, DISP_MODE, DISP_DRIVE, MMR_READY, MMR_GRANT, DMA_READY;
    logic DMA_REAL, IRQ_PULSE, IRQ_GIE, go, g_rnw, real_ack, vph = 1'b0, vrun;
    logic [NUM_CH-1:0]       CH_WR, CH_EN, CH_RST, CH_BLK, FIFO_FLUSH, REGS_DEFAULT, CNT_RUN, FIFO_LIVE;
    logic [CFG_W-1:0]        CH_CFG_WD;
    logic [NUM_CH*CFG_W-1:0] CH_CFG;
    logic [NUM_IRQ-1:0]      IRQ_MASK_WD, IRQ_CLR_WD, IRQ_SRC, IRQ_FLAGS, IRQ_MASK;
    logic [NUM_PINS-1:0]     PIN_FUNC_GPIO, GPIO_OUT, GPIO_OE, CORE_OUT, CORE_OE, PIN_OUT, PIN_OE;
    logic [NUM_EVT-1:0]      DMA_EVT_REQ, DMA_EVT;
    logic [CH_SEL_W-1:0]     DMA_CH, g_ch;
    int                      bad_count = 0, num_checks = 0, pulses = 0, n_ack, p;
    vprc_top vprc_top_inst (.*);
    vprc_dma_model vprc_dma_model_inst (.CLK(CLK), .go(go), .rnw(g_rnw), .ch(g_ch),
        .DMA_READY(DMA_READY), .DMA_REAL(DMA_REAL), .DMA_REQ(DMA_REQ), .DMA_RNW(DMA_RNW),
        .DMA_CH(DMA_CH), .real_ack(real_ack), .n_ack(n_ack));
    assign VCLK_IN_B = ~VCLK_IN_A;
    always #5 CLK = ~CLK;
    // video clock at a quarter rate, can be stopped to stall resets
    always @(posedge CLK) begin
        vph <= ~vph;
        if (vrun && vph) VCLK_IN_A <= #1 ~VCLK_IN_A;
        if (IRQ_PULSE === 1'b1) pulses <= pulses + 1;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n = 1);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic peripheral_control_register(input logic en);
        PCR_EN_WD = en;
        PCR_WR = 1'b1;
        tick();
        PCR_WR = 1'b0;
        tick();
    endtask
    task automatic pctl(input logic h, r, d);
        {PCTL_HALT_WD, PCTL_RST_WD, PCTL_DISP_WD} = {h, r, d};
        PCTL_WR = 1'b1;
        tick();
        PCTL_WR = 1'b0;
        tick();
    endtask
    task automatic chw(input int c, input logic en, r, b, input logic [CFG_W-1:0] cfg);
        {CH_EN_WD, CH_RST_WD, CH_BLK_WD, CH_CFG_WD} = {en, r, b, cfg};
        CH_WR = 3'h1 << c;
        tick();
        CH_WR = 3'h0;
        tick();
    endtask
    task automatic mmr(input logic gpio, input logic grant);
        MMR_GPIO = gpio;
        MMR_REQ = 1'b1;
        tick();
        MMR_REQ = 1'b0;
        check(MMR_READY, 1'b1);
        check(MMR_GRANT, grant);
        tick();
    endtask
    task automatic dma(input logic rnw, input logic [CH_SEL_W-1:0] ch, input logic exp);
        int a;
        a = n_ack;
        {g_rnw, g_ch, go} = {rnw, ch, 1'b1};
        tick();
        go = 1'b0;
        tick(3);
        check(n_ack - a, 1);
        check(real_ack, exp);
    endtask
    // poll reset bits before further writes
    task automatic wait_idle;
        int n;
        n = 0;
        while ((PORT_RST | (|CH_RST)) !== 1'b0 && n < 100) begin
            tick();
            n++;
        end
        check(n < 100, 1'b1);
    endtask
    task automatic irq(input logic [NUM_IRQ-1:0] src, clr, msk, input logic gie);
        IRQ_SRC = src;
        {IRQ_CLR_WD, IRQ_MASK_WD, IRQ_GIE_WD} = {clr, msk, gie};
        IRQ_CLR_WR = |clr;
        IRQ_MASK_WR = |msk | gie;
        tick();
        {IRQ_SRC, IRQ_CLR_WR, IRQ_MASK_WR} = '0;
        tick(3);
    endtask
    initial begin
        {CLK, RSTN, BUS_RST, PCR_WR, PCR_EN_WD, PCTL_WR, PCTL_HALT_WD, PCTL_RST_WD, PCTL_DISP_WD,
         CH_WR, CH_EN_WD, CH_RST_WD, CH_BLK_WD, CH_CFG_WD, IRQ_MASK_WR, IRQ_MASK_WD, IRQ_GIE_WD,
         IRQ_CLR_WR, IRQ_CLR_WD, IRQ_SRC, MMR_REQ, MMR_GPIO, DMA_EVT_REQ,
         go, g_rnw, g_ch} = '0;
        {PIN_FUNC_GPIO, GPIO_OUT, GPIO_OE, CORE_OUT, CORE_OE} = {24'h00000f, 24'h00000a, {72{1'b1}}};
        vrun = 1'b1;
        tick(12);
        check(PIN_OE, 24'h0);
        RSTN = 1'b1;
        tick();
        mmr(1'b0, 1'b0);
        mmr(1'b1, 1'b1);
        dma(1'b1, 2'h0, 1'b0);
        check(MOD_CLK_EN, 1'b0);
        check(PIN_OE, 24'h00000f);
        peripheral_control_register(1'b1);
        check(MOD_CLK_EN, 1'b1);
        mmr(1'b0, 1'b1);
        pctl(1'b1, 1'b0, 1'b1);
        check(DISP_MODE, 1'b1);
        check(PIN_OE, 24'h00000f);
        vrun = 1'b0;
        pctl(1'b1, 1'b1, 1'b1);
        tick(20);
        check(PORT_RST, 1'b1);
        check({PERIPH_EN, DISP_MODE, FIFO_FLUSH}, 5'h17);
        vrun = 1'b1;
        wait_idle();
        check({PORT_RST, PORT_HALT}, 2'h1);
        pctl(1'b0, 1'b0, 1'b0);
        pctl(1'b1, 1'b0, 1'b1);
        check({PORT_HALT, DISP_MODE}, 2'h0);
        check(PIN_OE, 24'h00000f);
        chw(0, 1'b1, 1'b0, 1'b1, 8'h5a);
        chw(0, 1'b1, 1'b0, 1'b1, 8'ha5);
        check({CH_CFG[7:0], CNT_RUN[0]}, 9'h0b5);
        DMA_EVT_REQ = 6'h3f;
        tick();
        check(DMA_EVT, 6'h00);
        chw(0, 1'b1, 1'b0, 1'b0, 8'h00);
        tick();
        check(DMA_EVT, 6'h07);
        check(FIFO_LIVE[0], 1'b1);
        dma(1'b1, 2'h0, 1'b1);
        dma(1'b0, 2'h0, 1'b0);
        chw(2, 1'b1, 1'b0, 1'b1, 8'h00);
        check(CNT_RUN[2], 1'b1);
        check({DISP_DRIVE, PIN_OE}, 25'h17fffff);
        check(PIN_OUT, 24'hfffffa);
        // channel resets: capture a, capture b, display
        for (int c = 0; c < NUM_CH; c++) begin
            chw(c, 1'b0, 1'b1, 1'b0, 8'h00);
            tick(2);
            check({FIFO_FLUSH[c], REGS_DEFAULT[c], DMA_EVT}, 8'hc0);
            wait_idle();
            check({CH_RST[c], CH_EN[c], CH_BLK[c], CH_CFG[c*CFG_W+:CFG_W]}, 11'h100);
        end
        DMA_EVT_REQ = 6'h00;
        irq('0, '0, 12'hfff, 1'b1);
        check({IRQ_GIE, IRQ_MASK}, 13'h1fff);
        for (int i = 0; i < NUM_IRQ; i++) begin
            p = pulses;
            irq(12'h1 << i, '0, '0, 1'b0);
            check(pulses - p, 1);
            irq('0, 12'h1 << i, '0, 1'b0);
            check(IRQ_FLAGS, 12'h0);
        end
        p = pulses;
        irq(12'h001, '0, '0, 1'b0);
        irq(12'h002, '0, '0, 1'b0);
        check(pulses - p, 1);
        irq('0, 12'h002, '0, 1'b0);
        check(pulses - p, 2);
        irq('0, 12'h001, 12'h001, 1'b1);
        irq(12'h008, '0, '0, 1'b0);
        irq('0, '0, 12'hfff, 1'b0);
        check(pulses - p, 2);
        check(IRQ_FLAGS, 12'h008);
        BUS_RST = 1'b1;
        tick(2);
        check({PERIPH_EN, PORT_HALT, PIN_OE, IRQ_FLAGS}, 38'h1000000000);
        BUS_RST = 1'b0;
        tick();
        final_report();
    end
    initial begin
        #200000;
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
